// >>> src/ctr_pkg.sv
// Package of constants, types and arithmetic helpers for the current and temperature readout datapath.
package ctr_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ            = 20_000_000;
    localparam int CLK_PER_US        = CLK_HZ / 1_000_000;
    localparam int CUR_PERIOD_US     = 175_800;
    localparam int CUR_PERIOD_CYC    = CUR_PERIOD_US * CLK_PER_US;
    localparam int THERM_PERIOD_US   = 1_400_000;
    localparam int THERM_PERIOD_CYC  = THERM_PERIOD_US * CLK_PER_US;
    localparam int SETTLE_US         = 1_000;
    localparam int SETTLE_CYC        = SETTLE_US * CLK_PER_US;

    // ------------------------------------------------------------------
    // Register word indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [7:0] IDX_TEMPERATURE_VALUE   = 8'h08;
    localparam logic [7:0] IDX_CURRENT_VALUE       = 8'h0A;
    localparam logic [7:0] IDX_CURRENT_AVERAGE     = 8'h0B;
    localparam logic [7:0] IDX_TEMPERATURE_AVERAGE = 8'h16;
    localparam logic [7:0] IDX_TEMPERATURE_EXTREMES = 8'h1A;
    localparam logic [7:0] IDX_CURRENT_EXTREMES    = 8'h1C;
    localparam logic [7:0] IDX_READOUT_CONFIG      = 8'h1D;
    localparam logic [7:0] IDX_THERMISTOR_RATIO    = 8'h27;
    localparam logic [7:0] IDX_AVERAGING_CONFIG    = 8'h29;
    localparam logic [7:0] IDX_TEMPERATURE_GAIN    = 8'h2C;
    localparam logic [7:0] IDX_TEMPERATURE_OFFSET  = 8'h2D;
    localparam logic [7:0] IDX_CURRENT_GAIN        = 8'h2E;
    localparam logic [7:0] IDX_CURRENT_OFFSET      = 8'h2F;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RST_EXTREMES     = 16'h807F;
    localparam logic [15:0] RST_CURRENT_GAIN        = 16'h4000;
    localparam logic [15:0] RST_CURRENT_OFFSET         = 16'h0000;
    localparam logic [15:0] RST_TEMPERATURE_GAIN        = 16'h4000;
    localparam logic [15:0] RST_TEMPERATURE_OFFSET         = 16'h0000;
    localparam logic [15:0] RST_TEMPERATURE  = 16'h1600;
    localparam logic [15:0] RST_CUR_AVG      = 16'h0000;
    localparam logic [15:0] RST_TEMP_AVG     = 16'h1600;
    localparam logic [15:0] RST_RATIO        = 16'h0000;
    localparam logic [15:0] RST_CONFIG       = 16'h0005;
    localparam logic [15:0] RST_FILTER       = 16'h0404;
    localparam logic [15:0] ZERO16           = 16'h0000;

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    localparam int              GAIN_FRAC       = 14;
    localparam int              AVG_FRAC        = 16;
    localparam logic [4:0]      CUR_SHIFT_BASE  = 5'h02;
    localparam logic [4:0]      TEMP_SHIFT_BASE = 5'h08;
    localparam logic signed [33:0] SAT_MAX      = 34'sh0_0000_7FFF;
    localparam logic signed [33:0] SAT_MIN      = -34'sh0_0000_8000;
    localparam logic [15:0]     WORD_MAX        = 16'h7FFF;
    localparam logic [15:0]     WORD_MIN        = 16'h8000;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [11:0] reserved;
        logic        force_divider_pullup;
        logic        divider_power_switch;
        logic        host_temp_select;
        logic        temp_meas_enable;
    } ctr_config_t;

    typedef struct packed {
        logic [4:0] reserved_hi;
        logic [2:0] temp_window;
        logic [3:0] reserved_lo;
        logic [3:0] cur_window;
    } ctr_filter_t;

    typedef enum logic [1:0] {
        TH_IDLE    = 2'b00,
        TH_SETTLE  = 2'b01,
        TH_CONVERT = 2'b10
    } ctr_therm_state_t;

    // Gain is a signed fraction with 2^14 as unity; the offset counts double.
    function automatic logic [15:0] ctr_calibrate(input logic signed [16:0] x,
                                                  input logic signed [15:0] g,
                                                  input logic signed [15:0] o);
        logic signed [32:0] prod;
        logic signed [33:0] sum;
        prod = x * g;
        sum  = 34'(prod >>> GAIN_FRAC) + (34'(o) <<< 1);
        if (sum > SAT_MAX) begin
            return WORD_MAX;
        end else if (sum < SAT_MIN) begin
            return WORD_MIN;
        end
        return sum[15:0];
    endfunction

    // Byte-lane merge of a 16-bit register with the low half of the bus word.
    function automatic logic [15:0] ctr_merge(input logic [15:0] old,
                                              input logic [15:0] wdat,
                                              input logic [1:0]  sel);
        return {sel[1] ? wdat[15:8] : old[15:8], sel[0] ? wdat[7:0] : old[7:0]};
    endfunction

endpackage

// >>> src/ctr_datapath.sv
// Current and temperature readout datapath with a classic Wishbone register slave.
`timescale 1ns/1ps

// Function
// - Current average over a 0.7 s to 6.4 h window, same weight as samples.
// - First current sample after reset seeds the current average.
// - Current average freezes at its last value in shutdown.
// - Each current sample replaces the stored maximum or minimum it exceeds.
// - Current extremes reset to max 80h, min 7Fh; host may write 807Fh.
// - Current extremes are signed bytes at 0.4 mV per sense resistance.
// - Current equals raw times gain over 16384 plus twice the offset.
// - Current gain and offset are signed, defaulting to 4000h and 0000h.
// - Ratio measured every 1.4 s only while active with measurement enabled.
// - Each conversion switches the pullup on, then waits a settling time.
// - Power switch set and force clear turns the pullup off after conversion.
// - Temperature is ratio times gain over 16384 plus twice offset, per update.
// - With host select set, temperature comes only from host writes.
// - Ratio holds its last value in shutdown or with measurement disabled.
// - Temperature is signed at 0.0039 C per bit; upper byte is whole degrees.
// - Temperature average over 6 min to 12.7 h, seeded first; in shutdown only host writes with host select set move it.
// - Temperature extremes are signed whole-degree bytes, reset to 807Fh.
// - 256 sixteen-bit word locations, each moved as two bytes.
// - Reading the upper byte latches both bytes for the rest of the read.
// - Registers reset to defaults, kept in shutdown; reserved words read zero.
// - A new current sample is requested every 175.8 ms while active.
module ctr_datapath
    import ctr_pkg::*;
#(
    parameter int unsigned CUR_PERIOD_CYCLES   = CUR_PERIOD_CYC,
    parameter int unsigned THERM_PERIOD_CYCLES = THERM_PERIOD_CYC,
    parameter int unsigned SETTLE_CYCLES       = SETTLE_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        active_i,
    output logic             cur_conv_req_o,
    input  wire logic        cur_raw_valid_i,
    input  wire logic [15:0] cur_raw_i,
    output logic             divider_pullup_en_o,
    output logic             therm_conv_req_o,
    input  wire logic        therm_ratio_valid_i,
    input  wire logic [15:0] therm_ratio_i
);

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (CUR_PERIOD_CYCLES < 2 || THERM_PERIOD_CYCLES < 2 || SETTLE_CYCLES < 1) begin : g_bad_param
        $error("ctr_datapath: period and settle counts must be at least two and one cycles");
    end

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic             ack_q;
    logic [31:0]      dat_q;
    logic [15:0]      hold_q;
    logic [7:0]       hold_idx_q;
    logic             hold_vld_q;
    logic [15:0]      current_gain_q;
    logic [15:0]      current_offset_q;
    logic [15:0]      temperature_gain_q;
    logic [15:0]      temperature_offset_q;
    ctr_config_t      cfg_q;
    ctr_filter_t      filt_q;
    logic [15:0]      cur_q;
    logic             cur_upd_q;
    logic [15:0]      temp_q;
    logic             temp_upd_q;
    logic [15:0]      ratio_q;
    logic [31:0]      cur_cnt_q;
    logic [31:0]      therm_cnt_q;
    logic             cur_tick_q;
    logic             therm_tick_q;
    logic             cur_req_q;
    logic             therm_req_q;
    logic             pullup_q;
    logic [31:0]      settle_cnt_q;
    ctr_therm_state_t th_state_q;

    logic             bus_req;
    logic             bus_wr;
    logic             bus_rd;
    logic [7:0]       idx;
    logic [15:0]      wdat;
    logic [1:0]       wsel;
    logic [15:0]      rd_word;
    logic             ratio_evt;
    logic             release_pullup;

    logic [1:0]       ch_upd;
    logic [15:0]      ch_smp   [2];
    logic [4:0]       ch_shift [2];
    logic [1:0]       ch_ext_wr;
    logic [15:0]      ch_rst_avg [2];
    logic [15:0]      ch_avg   [2];
    logic [15:0]      ch_ext   [2];

    assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
    assign bus_wr  = bus_req & wb_we_i;
    assign bus_rd  = bus_req & ~wb_we_i;
    assign idx     = wb_adr_i[9:2];
    assign wdat    = wb_dat_i[15:0];
    assign wsel    = wb_sel_i[1:0];

    assign wb_ack_o            = ack_q;
    assign wb_dat_o            = dat_q;
    assign cur_conv_req_o      = cur_req_q;
    assign therm_conv_req_o    = therm_req_q;
    assign divider_pullup_en_o = pullup_q;

    // ------------------------------------------------------------------
    // Wishbone slave: one wait state, registered answer
    // ------------------------------------------------------------------
    // word map decode
    always_comb begin
        case (idx)
            IDX_TEMPERATURE_VALUE:    rd_word = temp_q;
            IDX_CURRENT_VALUE:        rd_word = cur_q;
            IDX_CURRENT_AVERAGE:      rd_word = ch_avg[0];
            IDX_TEMPERATURE_AVERAGE:  rd_word = ch_avg[1];
            IDX_TEMPERATURE_EXTREMES: rd_word = ch_ext[1];
            IDX_CURRENT_EXTREMES:     rd_word = ch_ext[0];
            IDX_READOUT_CONFIG:       rd_word = cfg_q;
            IDX_THERMISTOR_RATIO:     rd_word = ratio_q;
            IDX_AVERAGING_CONFIG:     rd_word = filt_q;
            IDX_TEMPERATURE_GAIN:     rd_word = temperature_gain_q;
            IDX_TEMPERATURE_OFFSET:   rd_word = temperature_offset_q;
            IDX_CURRENT_GAIN:         rd_word = current_gain_q;
            IDX_CURRENT_OFFSET:       rd_word = current_offset_q;
            default:                  rd_word = ZERO16;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= bus_req;
        end
    end

    // A lower-byte read that follows an upper-byte read of the same word returns the latched copy.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q      <= 32'h0000_0000;
            hold_q     <= ZERO16;
            hold_idx_q <= 8'h00;
            hold_vld_q <= 1'b0;
        end else if (bus_rd) begin
            if (wsel[1]) begin
                dat_q      <= {ZERO16, rd_word};
                hold_q     <= rd_word;
                hold_idx_q <= idx;
                hold_vld_q <= 1'b1;
            end else if (hold_vld_q && hold_idx_q == idx) begin
                dat_q      <= {ZERO16, hold_q};
                hold_vld_q <= 1'b0;
            end else begin
                dat_q      <= {ZERO16, rd_word};
                hold_vld_q <= 1'b0;
            end
        end else if (bus_wr) begin
            hold_vld_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    // defaults at reset, no shutdown effect
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            current_gain_q <= RST_CURRENT_GAIN;
            current_offset_q  <= RST_CURRENT_OFFSET;
            temperature_gain_q <= RST_TEMPERATURE_GAIN;
            temperature_offset_q  <= RST_TEMPERATURE_OFFSET;
            cfg_q   <= RST_CONFIG;
            filt_q  <= RST_FILTER;
        end else if (bus_wr) begin
            case (idx)
                IDX_CURRENT_GAIN:       current_gain_q <= ctr_merge(current_gain_q, wdat, wsel);
                IDX_CURRENT_OFFSET:     current_offset_q  <= ctr_merge(current_offset_q, wdat, wsel);
                IDX_TEMPERATURE_GAIN:   temperature_gain_q <= ctr_merge(temperature_gain_q, wdat, wsel);
                IDX_TEMPERATURE_OFFSET: temperature_offset_q  <= ctr_merge(temperature_offset_q, wdat, wsel);
                IDX_READOUT_CONFIG:     cfg_q   <= ctr_merge(cfg_q, wdat, wsel);
                IDX_AVERAGING_CONFIG:   filt_q  <= ctr_merge(filt_q, wdat, wsel);
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Sample-rate dividers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_cnt_q  <= 32'h0000_0000;
            cur_tick_q <= 1'b0;
        end else begin
            cur_tick_q <= (cur_cnt_q == 32'(CUR_PERIOD_CYCLES - 1));
            cur_cnt_q  <= (cur_cnt_q == 32'(CUR_PERIOD_CYCLES - 1)) ? 32'h0000_0000 : cur_cnt_q + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            therm_cnt_q  <= 32'h0000_0000;
            therm_tick_q <= 1'b0;
        end else begin
            therm_tick_q <= (therm_cnt_q == 32'(THERM_PERIOD_CYCLES - 1));
            therm_cnt_q  <= (therm_cnt_q == 32'(THERM_PERIOD_CYCLES - 1)) ? 32'h0000_0000
                                                                         : therm_cnt_q + 32'h0000_0001;
        end
    end

    // ------------------------------------------------------------------
    // Current channel
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cur_req_q <= 1'b0;
            cur_q     <= RST_CUR_AVG;
            cur_upd_q <= 1'b0;
        end else begin
            cur_req_q <= cur_tick_q & active_i;
            cur_upd_q <= cur_raw_valid_i & active_i;
            if (cur_raw_valid_i && active_i) begin
                cur_q <= ctr_calibrate(17'(signed'(cur_raw_i)), signed'(current_gain_q), signed'(current_offset_q));
            end
        end
    end

    // ------------------------------------------------------------------
    // Thermistor sequencer
    // ------------------------------------------------------------------
    assign ratio_evt      = (th_state_q == TH_CONVERT) & therm_ratio_valid_i & active_i;
    assign release_pullup = cfg_q.divider_power_switch & ~cfg_q.force_divider_pullup;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            th_state_q   <= TH_IDLE;
            settle_cnt_q <= 32'h0000_0000;
            therm_req_q  <= 1'b0;
            pullup_q     <= 1'b0;
        end else begin
            therm_req_q <= 1'b0;
            case (th_state_q)
                TH_IDLE: begin
                    // start only when active and enabled
                    if (therm_tick_q && active_i && cfg_q.temp_meas_enable) begin
                        pullup_q     <= 1'b1;
                        settle_cnt_q <= 32'h0000_0000;
                        th_state_q   <= TH_SETTLE;
                    end else if (release_pullup) begin
                        pullup_q <= 1'b0;
                    end
                end
                TH_SETTLE: begin
                    if (!active_i) begin
                        th_state_q <= TH_IDLE;
                    end else if (settle_cnt_q == 32'(SETTLE_CYCLES - 1)) begin
                        therm_req_q <= 1'b1;
                        th_state_q  <= TH_CONVERT;
                    end else begin
                        settle_cnt_q <= settle_cnt_q + 32'h0000_0001;
                    end
                end
                TH_CONVERT: begin
                    if (!active_i || therm_ratio_valid_i) begin
                        th_state_q <= TH_IDLE;
                        if (release_pullup) begin
                            pullup_q <= 1'b0;
                        end
                    end
                end
                default: th_state_q <= TH_IDLE;
            endcase
            if (cfg_q.force_divider_pullup) begin
                pullup_q <= 1'b1;
            end
        end
    end

    // ratio changes only on a completed conversion
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ratio_q <= RST_RATIO;
        end else if (ratio_evt) begin
            ratio_q <= therm_ratio_i;
        end
    end

    // ------------------------------------------------------------------
    // Temperature value
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            temp_q     <= RST_TEMPERATURE;
            temp_upd_q <= 1'b0;
        end else begin
            temp_upd_q <= 1'b0;
            if (bus_wr && idx == IDX_TEMPERATURE_VALUE) begin
                temp_q     <= ctr_merge(temp_q, wdat, wsel);
                temp_upd_q <= cfg_q.host_temp_select;
            end else if (ratio_evt && cfg_q.temp_meas_enable && !cfg_q.host_temp_select) begin
                temp_q     <= ctr_calibrate({1'b0, therm_ratio_i}, signed'(temperature_gain_q), signed'(temperature_offset_q));
                temp_upd_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Averaging and extremes, one lane per channel
    // ------------------------------------------------------------------
    assign ch_upd       = {temp_upd_q, cur_upd_q};
    assign ch_smp[0]    = cur_q;
    assign ch_smp[1]    = temp_q;
    assign ch_shift[0]  = CUR_SHIFT_BASE + 5'(filt_q.cur_window);
    assign ch_shift[1]  = TEMP_SHIFT_BASE + 5'(filt_q.temp_window);
    assign ch_ext_wr[0] = bus_wr && idx == IDX_CURRENT_EXTREMES;
    assign ch_ext_wr[1] = bus_wr && idx == IDX_TEMPERATURE_EXTREMES;
    assign ch_rst_avg[0] = RST_CUR_AVG;
    assign ch_rst_avg[1] = RST_TEMP_AVG;

    for (genvar ch = 0; ch < 2; ch++) begin : g_chan
        logic signed [31:0] acc_q;
        logic               seeded_q;
        logic signed [32:0] diff;
        logic signed [7:0]  max_q;
        logic signed [7:0]  min_q;
        logic signed [7:0]  max_base;
        logic signed [7:0]  min_base;
        logic signed [7:0]  smp_byte;
        logic [15:0]        merged;

        assign diff     = 33'(signed'({ch_smp[ch], ZERO16})) - 33'(acc_q);
        assign merged   = ctr_merge({max_q, min_q}, wdat, wsel);
        assign max_base = ch_ext_wr[ch] ? signed'(merged[15:8]) : max_q;
        assign min_base = ch_ext_wr[ch] ? signed'(merged[7:0]) : min_q;
        assign smp_byte = signed'(ch_smp[ch][15:8]);

        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                acc_q    <= signed'({ch_rst_avg[ch], ZERO16});
                seeded_q <= 1'b0;
            // no update without a sample, so shutdown freezes it except for host temperature writes with host select set
            end else if (ch_upd[ch]) begin
                seeded_q <= 1'b1;
                if (!seeded_q) begin
                    acc_q <= signed'({ch_smp[ch], ZERO16});
                end else begin
                    acc_q <= acc_q + 32'(diff >>> ch_shift[ch]);
                end
            end
        end

        // compare against both bounds; a sample in the write cycle still counts
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                {max_q, min_q} <= RST_EXTREMES;
            end else begin
                max_q <= max_base;
                min_q <= min_base;
                // upper byte is the coarse value
                if (ch_upd[ch] && smp_byte > max_base) begin
                    max_q <= smp_byte;
                end
                if (ch_upd[ch] && smp_byte < min_base) begin
                    min_q <= smp_byte;
                end
            end
        end

        assign ch_avg[ch] = acc_q[31:16];
        assign ch_ext[ch] = {max_q, min_q};
    end

endmodule // ctr_datapath

// >>> dv/ctr_sva.sv
// Concurrent checks on the readout datapath ports.
`timescale 1ns/1ps
module ctr_sva #(parameter int unsigned SETTLE_CYCLES = 5) (
    input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o, active_i,
    input wire logic cur_conv_req_o, divider_pullup_en_o, therm_conv_req_o, therm_ratio_valid_i
);
    localparam int SREQ = SETTLE_CYCLES;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_ack_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_settle; $rose(divider_pullup_en_o) |-> ##SREQ (therm_conv_req_o || !active_i); endproperty
    a_settle: assert property (p_settle) else $error("sample not after settling");
    property p_req_pu; therm_conv_req_o |-> divider_pullup_en_o; endproperty
    a_req_pu: assert property (p_req_pu) else $error("sample with pullup off");
    property p_pu_act; $rose(divider_pullup_en_o) |-> $past(active_i); endproperty
    a_pu_act: assert property (p_pu_act) else $error("conversion in shutdown");
    property p_pu_off;
        $fell(divider_pullup_en_o) |-> $past(therm_ratio_valid_i) || $past(therm_ratio_valid_i, 2)
            || !$past(active_i) || !$past(active_i, 2);
    endproperty
    a_pu_off: assert property (p_pu_off) else $error("pullup fell early");
    property p_cur_gap; cur_conv_req_o |=> !cur_conv_req_o [*8]; endproperty
    a_cur_gap: assert property (p_cur_gap) else $error("current request too soon");
endmodule // ctr_sva
bind ctr_datapath ctr_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .active_i(active_i), .cur_conv_req_o(cur_conv_req_o),
    .divider_pullup_en_o(divider_pullup_en_o), .therm_conv_req_o(therm_conv_req_o),
    .therm_ratio_valid_i(therm_ratio_valid_i));

// >>> dv/ctr_fe_model.sv
// Front-end model: answers each conversion request after a set delay.
`timescale 1ns/1ps
module ctr_fe_model (
    input  wire logic        clk_i, cur_req_i, therm_req_i,
    input  wire logic [3:0]  dly_i,
    input  wire logic [15:0] cur_code_i, ratio_code_i,
    output logic             cur_vld_o, therm_vld_o,
    output logic      [15:0] cur_o, ratio_o
);
    logic [3:0] cc_q = 4'h0, tc_q = 4'h0;
    initial {cur_vld_o, therm_vld_o, cur_o, ratio_o} = '0;
    always @(posedge clk_i) begin
        cc_q <= cur_req_i ? dly_i : (cc_q != 4'h0 ? cc_q - 4'h1 : 4'h0);
        tc_q <= therm_req_i ? dly_i : (tc_q != 4'h0 ? tc_q - 4'h1 : 4'h0);
        cur_vld_o <= cc_q == 4'h1;
        therm_vld_o <= tc_q == 4'h1;
        cur_o <= cc_q == 4'h1 ? cur_code_i : ~cur_o;
        ratio_o <= tc_q == 4'h1 ? ratio_code_i : ~ratio_o;
    end
endmodule // ctr_fe_model

// >>> dv/ctr_tb.sv
// Self-checking bench for the readout datapath.
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, active_i = 1'b0;
    logic [9:0] wb_adr_i = '0;
    logic [3:0] wb_sel_i = '0, dly = 4'h2;
    logic [31:0] wb_dat_i = '0, wb_dat_o, rdat;
    logic wb_ack_o, cur_conv_req_o, cur_raw_valid_i, divider_pullup_en_o, therm_conv_req_o, therm_ratio_valid_i;
    logic [15:0] cur_raw_i, therm_ratio_i, cur_code = 16'h1000, ratio_code = 16'h2000;
    int fails = 0, n_tests = 0;
    logic [7:0] ridx [10] = '{8'h2E, 8'h2F, 8'h2C, 8'h2D, 8'h08, 8'h1A, 8'h1C, 8'h16, 8'h27, 8'h0C};
    logic [15:0] rexp [10] = '{16'h4000, 16'h0000, 16'h4000, 16'h0000, 16'h1600, 16'h807F, 16'h807F,
                               16'h1600, 16'h0000, 16'h0000};
    ctr_datapath #(.CUR_PERIOD_CYCLES(50), .THERM_PERIOD_CYCLES(200), .SETTLE_CYCLES(5)) DUT (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .active_i(active_i),
        .cur_conv_req_o(cur_conv_req_o), .cur_raw_valid_i(cur_raw_valid_i), .cur_raw_i(cur_raw_i),
        .divider_pullup_en_o(divider_pullup_en_o), .therm_conv_req_o(therm_conv_req_o),
        .therm_ratio_valid_i(therm_ratio_valid_i), .therm_ratio_i(therm_ratio_i));
    ctr_fe_model u_fe (.clk_i(clk_i), .cur_req_i(cur_conv_req_o), .therm_req_i(therm_conv_req_o),
        .dly_i(dly), .cur_code_i(cur_code), .ratio_code_i(ratio_code), .cur_vld_o(cur_raw_valid_i),
        .therm_vld_o(therm_ratio_valid_i), .cur_o(cur_raw_i), .ratio_o(therm_ratio_i));
    always #25 clk_i = ~clk_i;
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Classic Wishbone cycle held until ack is sampled high.
    task automatic bus(input logic w, input logic [7:0] idx, input logic [1:0] s, input logic [15:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= w;
        wb_adr_i <= {idx, 2'b00}; wb_sel_i <= {2'b00, s}; wb_dat_i <= {16'h0000, d};
        do begin @(posedge clk_i); end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [15:0] exp);
        bus(1'b0, idx, 2'b11, 16'h0000);
        chk(rdat[15:0], exp);
        chk(rdat[31:16], 16'h0000);
    endtask
    initial begin
        repeat (4000) @(posedge clk_i);
        fails++;
        stop_test();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (ridx[i]) rd(ridx[i], rexp[i]);
        bus(1'b1, 8'h0C, 2'b11, 16'hFFFF);
        rd(8'h0C, 16'h0000);
        bus(1'b1, 8'h2E, 2'b11, 16'h2000);
        bus(1'b1, 8'h2F, 2'b01, 16'h0003);
        bus(1'b1, 8'h2D, 2'b11, 16'h0010);
        active_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        rd(8'h0A, 16'h0806);
        rd(8'h0B, 16'h0806);
        rd(8'h1C, 16'h0808);
        rd(8'h27, 16'h2000);
        rd(8'h08, 16'h2020);
        rd(8'h16, 16'h2020);
        rd(8'h1A, 16'h2020);
        cur_code <= 16'hF000;
        repeat (60) @(posedge clk_i);
        rd(8'h0A, 16'hF806);
        rd(8'h1C, 16'h08F8);
        active_i <= 1'b0;
        cur_code <= 16'h7000;
        ratio_code <= 16'h1000;
        repeat (300) @(posedge clk_i);
        rd(8'h0A, 16'hF806);
        rd(8'h1C, 16'h08F8);
        rd(8'h27, 16'h2000);
        bus(1'b1, 8'h1C, 2'b11, 16'h807F);
        rd(8'h1C, 16'h807F);
        bus(1'b1, 8'h1D, 2'b11, 16'h0007);
        bus(1'b1, 8'h08, 2'b11, 16'h1234);
        dly <= 4'h6;
        active_i <= 1'b1;
        repeat (300) @(posedge clk_i);
        rd(8'h1C, 16'h3838);
        rd(8'h08, 16'h1234);
        rd(8'h1A, 16'h2012);
        rd(8'h27, 16'h1000);
        stop_test();
    end
endmodule // tb
